/* design/cbc4_counter.sv */
// cascadable four-bit synchronous counter stage with apb control
// assumes pin qualifiers come from logic on CLK_I, so no synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "cbc4_consts.svh"

module cbc4_counter (
    // clock and reset
    input  wire logic                    CLK_I,
    input  wire logic                    RESET_N_I,
    // apb slave
    input  wire logic                    PSEL_I,
    input  wire logic                    PENABLE_I,
    input  wire logic                    PWRITE_I,
    input  wire logic [`CBC4_ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]             PWDATA_I,
    input  wire logic [3:0]              PSTRB_I,
    output logic      [31:0]             PRDATA_O,
    output logic                         PREADY_O,
    output logic                         PSLVERR_O,
    // counter pins
    input  wire logic                    SYNC_CLEAR_N_I,
    input  wire logic                    LOAD_N_I,
    input  wire logic [`CBC4_CNT_W-1:0]  PRESET_I,
    input  wire logic                    PARALLEL_COUNT_GATE_I,
    input  wire logic                    TRICKLE_COUNT_GATE_I,
    output logic      [`CBC4_CNT_W-1:0]  COUNT_O,
    output logic                         CARRY_OUT_O
);

    // apb phase and decode
    logic                 apb_setup;
    logic                 apb_done;
    logic                 wr_fire;
    logic                 wr_lane0;
    cbc4_pkg::cbc4_sel_t  sel;

    // apb answer registers
    logic                 pready_reg;
    logic                 pslverr_reg;
    logic [31:0]          prdata_reg;
    logic [31:0]          rdata_next;

    // software control
    logic                 gate_en_reg;
    logic                 sw_clear_reg;
    logic                 sw_load_reg;
    cbc4_pkg::cbc4_count_t preset_reg;

    // merged qualifiers and state
    logic                 eff_clear;
    logic                 eff_load;
    logic                 eff_count;
    cbc4_pkg::cbc4_count_t load_value;
    cbc4_pkg::cbc4_count_t state;
    logic                 all_ones;

    // setup phase opens a transfer, pready marks its only access cycle
    assign apb_setup = PSEL_I & ~PENABLE_I;
    assign apb_done  = PSEL_I & PENABLE_I & pready_reg;
    assign wr_fire   = apb_done & PWRITE_I;
    assign wr_lane0  = wr_fire & PSTRB_I[0];

    // address decode on the full byte address
    always_comb begin
        case (PADDR_I)
            `CBC4_OFS_CTRL:   sel = cbc4_pkg::CBC4_SEL_CTRL;
            `CBC4_OFS_PRESET: sel = cbc4_pkg::CBC4_SEL_PRESET;
            `CBC4_OFS_STATUS: sel = cbc4_pkg::CBC4_SEL_STATUS;
            default:          sel = cbc4_pkg::CBC4_SEL_NONE;
        endcase
    end

    // read mux; strobe bits of control always read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (sel)
            cbc4_pkg::CBC4_SEL_CTRL: begin
                rdata_next[`CBC4_CTRL_GATE_BIT] = gate_en_reg;
            end
            cbc4_pkg::CBC4_SEL_PRESET: begin
                rdata_next[`CBC4_CNT_W-1:0] = preset_reg;
            end
            cbc4_pkg::CBC4_SEL_STATUS: begin
                rdata_next[`CBC4_CNT_W-1:0]      = state;
                rdata_next[`CBC4_STAT_CARRY_BIT] = CARRY_OUT_O;
                rdata_next[`CBC4_STAT_TGATE_BIT] = TRICKLE_COUNT_GATE_I;
                rdata_next[`CBC4_STAT_PGATE_BIT] = PARALLEL_COUNT_GATE_I;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // fixed one access cycle; pready drops right after
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= apb_setup;
        end
    end

    // error answer for any address outside the map
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= apb_setup & (sel == cbc4_pkg::CBC4_SEL_NONE);
        end
    end

    // read data snapshot at setup, one edge ahead of completion
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            prdata_reg <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata_reg <= PWRITE_I ? 32'h0000_0000 : rdata_next;
        end
    end

    // software count gate, high after reset so pins alone decide
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            gate_en_reg <= `CBC4_CTRL_GATE_RST;
        end else if (wr_lane0 && sel == cbc4_pkg::CBC4_SEL_CTRL) begin
            gate_en_reg <= PWDATA_I[`CBC4_CTRL_GATE_BIT];
        end
    end

    // write-one strobes, live for exactly one cycle
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            sw_clear_reg <= 1'b0;
            sw_load_reg  <= 1'b0;
        end else begin
            sw_clear_reg <= wr_lane0 && sel == cbc4_pkg::CBC4_SEL_CTRL
                            && PWDATA_I[`CBC4_CTRL_CLR_BIT];
            sw_load_reg  <= wr_lane0 && sel == cbc4_pkg::CBC4_SEL_CTRL
                            && PWDATA_I[`CBC4_CTRL_LD_BIT];
        end
    end

    // software preset value for the strobe load
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            preset_reg <= `CBC4_PRESET_RST;
        end else if (wr_lane0 && sel == cbc4_pkg::CBC4_SEL_PRESET) begin
            preset_reg <= PWDATA_I[`CBC4_CNT_W-1:0];
        end
    end

    // pin and software sources merged; pin preset wins a joint load
    assign eff_clear  = ~SYNC_CLEAR_N_I | sw_clear_reg;
    assign eff_load   = ~LOAD_N_I | sw_load_reg;
    assign load_value = ~LOAD_N_I ? PRESET_I : preset_reg;
    assign eff_count  = PARALLEL_COUNT_GATE_I & TRICKLE_COUNT_GATE_I
                        & gate_en_reg;

    // state flip-flops and look-ahead
    cbc4_stage_core #(
        .WIDTH      (`CBC4_CNT_W)
    ) u_core (
        .clk_i      (CLK_I),
        .rst_n_i    (RESET_N_I),
        .clear_i    (eff_clear),
        .load_i     (eff_load),
        .count_i    (eff_count),
        .preset_i   (load_value),
        .state_o    (state),
        .all_ones_o (all_ones)
    );

    // carry stays combinational so the next stage counts on the same edge;
    // glitches follow trickle gate timing, harmless only on a trickle input
    assign CARRY_OUT_O = TRICKLE_COUNT_GATE_I & all_ones;

    // outputs straight from flip-flops
    assign COUNT_O   = state;
    assign PRDATA_O  = prdata_reg;
    assign PREADY_O  = pready_reg;
    assign PSLVERR_O = pslverr_reg;

    // checks on the count path
    AST_COUNT_STEP: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        eff_count && !eff_clear && !eff_load
        |=> state == 4'($past(state) + `CBC4_COUNT_ONE))
        else $error("count did not advance by one");

    AST_CARRY_PRODUCT: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        CARRY_OUT_O == (TRICKLE_COUNT_GATE_I && COUNT_O == `CBC4_COUNT_MAX))
        else $error("carry differs from gate and full count");

    AST_ARM_CARRY: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        state == `CBC4_COUNT_ARM && eff_count && !eff_clear && !eff_load
        |=> state == `CBC4_COUNT_MAX && CARRY_OUT_O == TRICKLE_COUNT_GATE_I)
        else $error("carry did not arm from 1110");

    AST_WRAP_DROP: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        CARRY_OUT_O && eff_count && !eff_clear && !eff_load
        |=> state == `CBC4_COUNT_ZERO && !CARRY_OUT_O)
        else $error("wrap did not clear the carry");

    AST_CLEAR_ZERO: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        !SYNC_CLEAR_N_I |=> COUNT_O == `CBC4_COUNT_ZERO)
        else $error("clear pin did not zero the state");

    AST_LOAD_COPY: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        SYNC_CLEAR_N_I && !sw_clear_reg && !LOAD_N_I
        |=> COUNT_O == $past(PRESET_I))
        else $error("load pin did not copy presets");

    AST_HOLD: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        !eff_clear && !eff_load
        && !(PARALLEL_COUNT_GATE_I && TRICKLE_COUNT_GATE_I)
        |=> $stable(COUNT_O))
        else $error("state moved with a gate low");

    AST_CHANGE_CAUSE: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        $changed(COUNT_O)
        |-> $past(eff_clear) || $past(eff_load) || $past(eff_count))
        else $error("state changed without a cause");

    AST_CLEAR_WINS: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        eff_clear && eff_load |=> state == `CBC4_COUNT_ZERO)
        else $error("load beat clear");

    // checks on the bus side
    AST_PREADY_ONE: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        apb_setup |=> PREADY_O ##1 !PREADY_O)
        else $error("pready not a single cycle after setup");

    AST_SW_CLEAR: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        wr_lane0 && sel == cbc4_pkg::CBC4_SEL_CTRL
        && PWDATA_I[`CBC4_CTRL_CLR_BIT]
        |=> ##1 COUNT_O == `CBC4_COUNT_ZERO)
        else $error("software clear did not zero the state");

    AST_UNMAPPED_ERR: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        apb_setup && sel == cbc4_pkg::CBC4_SEL_NONE
        |=> PSLVERR_O && PRDATA_O == 32'h0000_0000)
        else $error("unmapped address not answered with error");

endmodule

`default_nettype wire

/* design/cbc4_stage_core.sv */
// state flip-flops of one counter stage with per-bit look-ahead toggle
// assumes clear, load and count qualifiers already merged by the parent
`timescale 1ns/1ps
`default_nettype none
`include "cbc4_consts.svh"

module cbc4_stage_core #(
    parameter int unsigned WIDTH = `CBC4_CNT_W
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // mode qualifiers
    input  wire logic             clear_i,
    input  wire logic             load_i,
    input  wire logic             count_i,
    input  wire logic [WIDTH-1:0] preset_i,
    // state
    output logic      [WIDTH-1:0] state_o,
    output logic                  all_ones_o
);

    logic [WIDTH:0]   look_ahead;
    logic [WIDTH-1:0] state_reg;
    logic [WIDTH-1:0] state_next;

    // bit i toggles when counting and every lower bit is one
    assign look_ahead[0] = count_i;

    // per-bit toggle; clear before load before count
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            assign look_ahead[i+1] = look_ahead[i] & state_reg[i];
            assign state_next[i]   = clear_i ? 1'b0 :
                                     load_i  ? preset_i[i] :
                                     state_reg[i] ^ look_ahead[i];
        end
    endgenerate

    // whole word updates on one edge, so no counting spikes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign state_o    = state_reg;
    assign all_ones_o = &state_reg;

endmodule

`default_nettype wire

/* shared/cbc4_consts.svh */
// constants of the cascadable four-bit counter stage
// assumes inclusion by bare name from package and design files
// Notes on behaviour
// - enabled edge adds one, fifteen wraps to zero
// - carry is trickle gate AND all bits
// - from 1110 next count sets bit A, carry rises
// - wrap drops carry, next stage counts same edge
// - low clear zeroes state on next edge
// - low load copies presets, inhibits counting
// - count only with both gates high
// - all bits change together on rising edge
`ifndef CBC4_CONSTS_SVH
`define CBC4_CONSTS_SVH

// counter geometry
`define CBC4_CNT_W          4
`define CBC4_COUNT_ZERO     4'h0
`define CBC4_COUNT_ONE      4'h1
`define CBC4_COUNT_MAX      4'hf
`define CBC4_COUNT_ARM      4'he

// apb register byte offsets
`define CBC4_ADDR_W         12
`define CBC4_OFS_CTRL       12'h000
`define CBC4_OFS_PRESET     12'h004
`define CBC4_OFS_STATUS     12'h008

// control register fields
`define CBC4_CTRL_GATE_BIT  0
`define CBC4_CTRL_CLR_BIT   1
`define CBC4_CTRL_LD_BIT    2
`define CBC4_CTRL_GATE_RST  1'h1

// preset register reset value
`define CBC4_PRESET_RST     4'h0

// status register fields above the count in bits 3:0
`define CBC4_STAT_CARRY_BIT 4
`define CBC4_STAT_TGATE_BIT 5
`define CBC4_STAT_PGATE_BIT 6

`endif

/* shared/cbc4_pkg.sv */
// types of the cascadable four-bit counter stage
// assumes cbc4_consts.svh on the include path
`include "cbc4_consts.svh"

package cbc4_pkg;

    // one counter state word
    typedef logic [`CBC4_CNT_W-1:0] cbc4_count_t;

    // decoded apb register select
    typedef enum logic [1:0] {
        CBC4_SEL_CTRL   = 2'b00,
        CBC4_SEL_PRESET = 2'b01,
        CBC4_SEL_STATUS = 2'b10,
        CBC4_SEL_NONE   = 2'b11
    } cbc4_sel_t;

endpackage

/* verif/cbc4_counter_tb_top.sv */
// self-checking bench for the cascadable four-bit counter stage
// assumes the neighbour model and the shared constants header
`timescale 1ns/1ps
`default_nettype none
`include "cbc4_consts.svh"

module cbc4_counter_tb_top;
    // bench wiring
    logic        clk, rst_n, psel, pen, pwr, clr_n, ld_n, pg, tg, mod_en;
    logic        pready, pslverr, carry, dec_clr_n, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, preset, mod_last, cnt, nb_cnt;
    int          err_count, n_checks;

    cbc4_counter dut (
        .CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .SYNC_CLEAR_N_I(clr_n & dec_clr_n), .LOAD_N_I(ld_n), .PRESET_I(preset),
        .PARALLEL_COUNT_GATE_I(pg), .TRICKLE_COUNT_GATE_I(tg),
        .COUNT_O(cnt), .CARRY_OUT_O(carry)
    );

    cbc4_neighbour nb (
        .clk_i(clk), .rst_n_i(rst_n), .carry_i(carry), .count_i(cnt),
        .mod_en_i(mod_en), .mod_last_i(mod_last), .count_o(nb_cnt),
        .clear_n_o(dec_clr_n)
    );

    // free-running clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic bad(input string m);
        err_count++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    task automatic chk(input logic [3:0] c, input logic y, input string m);
        n_checks++;
        if (cnt !== c || carry !== y) bad(m);
    endtask

    task automatic cmp32(input logic [31:0] a, input logic [31:0] b, input string m);
        n_checks++;
        if (a !== b) bad(m);
    endtask

    // one apb transfer; pready is sampled at rising edges only, and the answer
    // is taken at the edge that finds it high before anything is released
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) bad("no ready");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // register defaults, soft load and clear, gate, refusals
    task automatic t_regs;
        apb(0, `CBC4_OFS_CTRL, 0, 4'hf, rd, er);
        cmp32(rd, 32'h1, "ctrl reset");
        apb(1, `CBC4_OFS_PRESET, 32'ha, 4'hf, rd, er);
        apb(1, `CBC4_OFS_PRESET, 32'h3, 4'h0, rd, er);
        apb(0, `CBC4_OFS_PRESET, 0, 4'hf, rd, er);
        cmp32(rd, 32'ha, "preset rw");
        tg <= 1'b1;
        apb(1, `CBC4_OFS_CTRL, 32'h5, 4'hf, rd, er);
        apb(0, `CBC4_OFS_STATUS, 0, 4'hf, rd, er);
        cmp32(rd, 32'h2a, "soft load status");
        apb(1, `CBC4_OFS_CTRL, 32'h0, 4'hf, rd, er);
        pg <= 1'b1;
        apb(1, `CBC4_OFS_STATUS, 32'hff, 4'hf, rd, er);
        cmp32({31'h0, er}, 32'h0, "status write error");
        apb(0, `CBC4_OFS_STATUS, 0, 4'hf, rd, er);
        cmp32(rd, 32'h6a, "gate off holds");
        pg <= 1'b0;
        apb(1, `CBC4_OFS_CTRL, 32'h3, 4'hf, rd, er);
        apb(0, `CBC4_OFS_CTRL, 0, 4'hf, rd, er);
        cmp32(rd, 32'h1, "ctrl strobes read");
        @(negedge clk);
        chk(4'h0, 1'b0, "soft clear");
        apb(0, 12'h00c, 0, 4'hf, rd, er);
        cmp32({er, rd[30:0]}, 32'h80000000, "unmapped read");
    endtask

    // full binary cycle with carry and the next stage
    task automatic t_count;
        logic [3:0] nb0;
        @(posedge clk);
        clr_n <= 1'b0;
        pg <= 1'b1;
        @(posedge clk);
        clr_n <= 1'b1;
        @(negedge clk);
        chk(4'h0, 1'b0, "pin clear");
        nb0 = nb_cnt;
        for (int i = 1; i <= 16; i++) begin
            @(negedge clk);
            chk(4'(i), i == 15, "count step");
        end
        n_checks++;
        if (nb_cnt !== nb0 + 4'h1) bad("next stage");
    endtask

    // each gate pair at full count; carry follows trickle at once
    task automatic t_gates;
        @(posedge clk);
        ld_n <= 1'b0;
        preset <= 4'hf;
        pg <= 1'b0;
        tg <= 1'b0;
        @(posedge clk);
        ld_n <= 1'b1;
        @(negedge clk);
        chk(4'hf, 1'b0, "load gates low");
        for (int g = 0; g < 4; g++) begin
            @(posedge clk);
            pg <= g[0];
            tg <= g[1];
            @(negedge clk);
            chk(4'hf, g[1], "gate hold");
        end
        @(negedge clk);
        chk(4'h0, 1'b0, "both gates wrap");
    endtask

    // load held, then clear with load, then clear alone
    task automatic t_prio;
        @(posedge clk);
        ld_n <= 1'b0;
        preset <= 4'h9;
        @(negedge clk);
        @(negedge clk);
        chk(4'h9, 1'b0, "pin load");
        @(posedge clk);
        clr_n <= 1'b0;
        @(negedge clk);
        chk(4'h9, 1'b0, "load inhibits count");
        @(posedge clk);
        ld_n <= 1'b1;
        @(negedge clk);
        chk(4'h0, 1'b0, "clear over load");
        @(posedge clk);
        clr_n <= 1'b1;
        @(negedge clk);
        chk(4'h0, 1'b0, "clear gates high");
    endtask

    // modulo six through the neighbour's decode
    task automatic t_mod;
        logic [3:0] e;
        @(posedge clk);
        clr_n <= 1'b0;
        mod_en <= 1'b1;
        @(posedge clk);
        clr_n <= 1'b1;
        e = 4'h0;
        for (int i = 0; i < 14; i++) begin
            @(negedge clk);
            chk(e, 1'b0, "modulo six");
            e = (e == 4'h5) ? 4'h0 : e + 4'h1;
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // idle inputs, reset, then the scenarios
    initial begin
        err_count = 0;
        n_checks = 0;
        {rst_n, psel, pen, pwr, pg, tg, mod_en} = 7'h0;
        {clr_n, ld_n} = 2'h3;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        preset = 4'h0;
        mod_last = 4'h5;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_count();
        t_gates();
        t_prio();
        t_mod();
        report_and_stop();
    end

    // hang guard, well beyond the hundred or so cycles needed
    initial begin
        repeat (4000) @(posedge clk);
        bad("watchdog expired");
        report_and_stop();
    end
endmodule

`default_nettype wire

/* verif/cbc4_neighbour.sv */
// next cascaded stage and modulo decode beside one counter stage
// assumes the same clock and synchronous reset as the stage it watches
`timescale 1ns/1ps
`default_nettype none

module cbc4_neighbour (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // from the stage under test
    input  wire logic       carry_i,
    input  wire logic [3:0] count_i,
    // modulo decode setup
    input  wire logic       mod_en_i,
    input  wire logic [3:0] mod_last_i,
    // to the stage under test and the bench
    output logic      [3:0] count_o,
    output logic            clear_n_o
);
    // carry feeds only this trickle gate, so its glitches cannot hurt
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count_o <= 4'h0;
        end else if (carry_i) begin
            count_o <= count_o + 4'h1;
        end
    end

    // decode of the last count pulls the stage clear low
    assign clear_n_o = !(mod_en_i && count_i == mod_last_i);
endmodule

`default_nettype wire
